// >>> hw/vosn_top.sv
// Vector operand swizzle network: lane stage, element stage, memory broadcast/convert.
// Assumes upstream holds inputs valid with issue_i; the ALU samples on opnd_valid_o.
module vosn_top
  import vosn_pkg::*;
(
  input  wire logic                  clk_i,          // Core clock, 50 MHz
  input  wire logic                  resetn_i,       // Async reset, active low
  input  wire logic                  ce_i,           // Clock enable, freezes all state
  input  wire logic                  issue_i,        // Instruction issues this cycle
  input  wire logic                  src_mem_i,      // Second source from in-line load
  input  wire logic                  shuf_i,         // Vector shuffle instruction
  input  wire logic                  is_float_i,     // Float-typed instruction
  input  wire logic                  mod_given_i,    // Swizzle field present
  input  wire logic                  mem_conv_i,     // Memory modifier is a conversion
  input  wire logic [SWZ_W-1:0]      swz_i,          // Three-bit swizzle field
  input  wire logic [LANE_SEL_W-1:0] shuf_lane_i,    // Shuffle lane selector
  input  wire logic [ELEM_SEL_W-1:0] shuf_elem_i,    // Shuffle element selector
  input  wire logic [VEC_W-1:0]      reg_src_i,      // Register-file second source
  input  wire logic [VEC_W-1:0]      mem_data_i,     // Load data, low bits first
  output logic      [VEC_W-1:0]      opnd_o,         // Swizzled operand to ALU
  output logic                       opnd_valid_o,   // Operand valid pulse
  output logic                       illegal_o,      // Illegal conversion pulse
  output logic                       rr_lat_o        // Extra-clock swizzle pulse
);

  typedef enum logic [1:0] {
    VOSN_BC_FULL = 2'h0,
    VOSN_BC_ONE  = 2'h1,
    VOSN_BC_FOUR = 2'h2
  } vosn_bc_t;

  // Element selector word for a register-register pattern
  function automatic logic [ELEM_SEL_W-1:0] vosn_rr_sel(input logic [SWZ_W-1:0] code);
    logic [ELEM_SEL_W-1:0] s;
    s = SEL_IDENT;
    case (code)
      SWZ_DCBA: s = SEL_IDENT;
      SWZ_CDAB: s = 8'hb1;                 // Swap pairs
      SWZ_BADC: s = 8'h4e;                 // Swap halves
      SWZ_DACB: s = 8'hc9;                 // Rotate low three, element0 <- b
      SWZ_AAAA: s = 8'h00;
      SWZ_BBBB: s = 8'h55;
      SWZ_CCCC: s = 8'haa;
      SWZ_DDDD: s = 8'hff;
      default:  s = SEL_IDENT;
    endcase
    return s;
  endfunction : vosn_rr_sel

  // Whether a conversion code is legal for the instruction type
  function automatic logic vosn_conv_ok(input logic [2:0] code, input logic fp);
    logic ok;
    ok = 1'b0;
    case (code)
      MEM_UINT8:  ok = 1'b1;
      MEM_SINT16: ok = 1'b1;
      MEM_SINT8:  ok = !fp;
      MEM_UINT16: ok = !fp;
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction : vosn_conv_ok

  vosn_lane_if lif ();

  vosn_src_t             src_kind;
  vosn_bc_t              bc_mode;
  logic [VEC_W-1:0]      stage_src;
  logic [LANE_SEL_W-1:0] lane_sel;
  logic [ELEM_SEL_W-1:0] elem_sel;
  logic                  elem_byp;
  logic                  conv_en;
  logic                  illegal;
  logic                  rr;

  // Decode of source form and swizzle field
  always_comb
  begin
    src_kind  = VOSN_SRC_IDLE;
    bc_mode   = VOSN_BC_FULL;
    stage_src = reg_src_i;                 // Copy only; source register untouched
    lane_sel  = SEL_IDENT;
    elem_sel  = SEL_IDENT;
    elem_byp  = 1'b1;
    conv_en   = 1'b0;
    illegal   = 1'b0;
    rr        = 1'b0;
    if (issue_i)
    begin
      if (shuf_i)
        src_kind = VOSN_SRC_SHUF;
      else if (src_mem_i)
        src_kind = VOSN_SRC_MEM;
      else
        src_kind = VOSN_SRC_REG;
    end
    case (src_kind)
      VOSN_SRC_SHUF:
      begin
        lane_sel = shuf_lane_i;
        elem_sel = shuf_elem_i;
        elem_byp = 1'b0;
      end
      VOSN_SRC_REG:
      begin
        if (mod_given_i)
        begin
          elem_sel = vosn_rr_sel(swz_i);
          elem_byp = 1'b0;
          rr       = 1'b1;
        end
      end
      VOSN_SRC_MEM:
      begin
        stage_src = mem_data_i;
        if (mod_given_i && mem_conv_i)
        begin
          // Conversion only, no broadcast
          if (vosn_conv_ok(swz_i, is_float_i))
            conv_en = 1'b1;
          else
            illegal = 1'b1;
        end
        else if (mod_given_i && swz_i == MEM_1TO16)
          bc_mode = VOSN_BC_ONE;
        else if (mod_given_i && swz_i == MEM_4TO16)
          bc_mode = VOSN_BC_FOUR;
        else
          bc_mode = VOSN_BC_FULL;
        case (bc_mode)
          VOSN_BC_ONE:
          begin
            lane_sel = SEL_ZERO;
            elem_sel = SEL_ZERO;
            elem_byp = 1'b0;
          end
          VOSN_BC_FOUR:
            lane_sel = SEL_ZERO;
          default:
          begin
            lane_sel = SEL_IDENT;
            elem_sel = SEL_IDENT;
          end
        endcase
      end
      default:
        lane_sel = SEL_IDENT;
    endcase
  end

  vosn_lane_mux u_lane (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .issue_i    (issue_i),
    .src_i      (stage_src),
    .lane_sel_i (lane_sel),
    .elem_sel_i (elem_sel),
    .elem_byp_i (elem_byp),
    .conv_i     (swz_i),
    .conv_en_i  (conv_en),
    .illegal_i  (illegal),
    .rr_i       (rr),
    .lo         (lif.src)
  );

  // Element stage, conversion and extra-clock slot for register swizzles
  logic [VEC_W-1:0] elem_out;
  logic [VEC_W-1:0] conv_out;
  logic [VEC_W-1:0] res;
  logic [VEC_W-1:0] hold_d, hold_q;
  logic             hold_v_d, hold_v_q;
  logic             hold_rr_d, hold_rr_q;
  logic             hold_ill_d, hold_ill_q;
  logic [VEC_W-1:0] opnd_d, opnd_q;
  logic             val_d, val_q;
  logic             ill_d, ill_q;
  logic             rrl_d, rrl_q;

  genvar gl, ge;
  generate
    for (gl = 0; gl < NUM_LANES; gl++)
    begin : g_lane
      for (ge = 0; ge < LANE_ELEMS; ge++)
      begin : g_elem
        // Rightmost selector pair drives element zero; same word in every lane
        localparam int unsigned BASE = gl*LANE_W;
        logic [1:0] pick;
        assign pick = lif.elem_sel[2*ge +: 2];
        assign elem_out[BASE + ge*ELEM_W +: ELEM_W] = lif.elem_bypass
            ? lif.tmp1[BASE + ge*ELEM_W +: ELEM_W]
            : lif.tmp1[BASE + int'(pick)*ELEM_W +: ELEM_W];
      end
    end
    for (ge = 0; ge < NUM_ELEMS; ge++)
    begin : g_conv
      logic [7:0]        b;
      logic [15:0]       h;
      logic [ELEM_W-1:0] cv;
      assign b = lif.tmp1[ge*8 +: 8];
      assign h = lif.tmp1[ge*16 +: 16];
      always_comb
      begin
        case (lif.conv)
          MEM_UINT8:  cv = {24'h000000, b};
          MEM_SINT8:  cv = {{24{b[7]}}, b};
          MEM_UINT16: cv = {16'h0000, h};
          MEM_SINT16: cv = {{16{h[15]}}, h};
          default:    cv = lif.tmp1[ge*ELEM_W +: ELEM_W];
        endcase
      end
      assign conv_out[ge*ELEM_W +: ELEM_W] = cv;
    end
  endgenerate

  always_comb
  begin
    res        = lif.conv_en ? conv_out : elem_out;
    hold_d     = hold_q;
    hold_v_d   = 1'b0;
    hold_rr_d  = hold_rr_q;
    hold_ill_d = hold_ill_q;
    opnd_d     = opnd_q;
    val_d      = 1'b0;
    ill_d      = 1'b0;
    rrl_d      = 1'b0;
    // A parked result leaves first, carrying its own flags
    if (hold_v_q)
    begin
      opnd_d = hold_q;
      val_d  = 1'b1;
      rrl_d  = hold_rr_q;
      ill_d  = hold_ill_q;
    end
    if (lif.valid)
    begin
      // Register swizzles park one clock; a plain op meeting a parked one waits too
      if (lif.rr || hold_v_q)
      begin
        hold_d     = res;
        hold_v_d   = 1'b1;
        hold_rr_d  = lif.rr;
        hold_ill_d = lif.illegal;
      end
      else
      begin
        opnd_d = res;
        val_d  = 1'b1;
        ill_d  = lif.illegal;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hold_q     <= '0;
      hold_v_q   <= 1'b0;
      hold_rr_q  <= 1'b0;
      hold_ill_q <= 1'b0;
      opnd_q   <= '0;
      val_q    <= 1'b0;
      ill_q    <= 1'b0;
      rrl_q    <= 1'b0;
    end
    else if (ce_i)
    begin
      hold_q     <= hold_d;
      hold_v_q   <= hold_v_d;
      hold_rr_q  <= hold_rr_d;
      hold_ill_q <= hold_ill_d;
      opnd_q   <= opnd_d;
      val_q    <= val_d;
      ill_q    <= ill_d;
      rrl_q    <= rrl_d;
    end
  end

  assign opnd_o       = opnd_q;
  assign opnd_valid_o = val_q;
  assign illegal_o    = ill_q;
  assign rr_lat_o     = rrl_q;

endmodule : vosn_top

// >>> hw/vosn_pkg.sv
// Package for the vector operand swizzle network: widths, field codes, pattern encodings.
// Assumes a single core clock domain; shared by the network and its lane-mux stage.
package vosn_pkg;

  localparam int unsigned VEC_W      = 512;
  localparam int unsigned LANE_W     = 128;
  localparam int unsigned ELEM_W     = 32;
  localparam int unsigned NUM_LANES  = 4;
  localparam int unsigned LANE_ELEMS = 4;
  localparam int unsigned NUM_ELEMS  = 16;
  localparam int unsigned SWZ_W      = 3;
  localparam int unsigned LANE_SEL_W = 8;
  localparam int unsigned ELEM_SEL_W = 8;

  // Register-register patterns, letters written left to right as element 3..0
  localparam logic [2:0] SWZ_DCBA = 3'h0;
  localparam logic [2:0] SWZ_CDAB = 3'h1;
  localparam logic [2:0] SWZ_BADC = 3'h2;
  localparam logic [2:0] SWZ_DACB = 3'h3;
  localparam logic [2:0] SWZ_AAAA = 3'h4;
  localparam logic [2:0] SWZ_BBBB = 3'h5;
  localparam logic [2:0] SWZ_CCCC = 3'h6;
  localparam logic [2:0] SWZ_DDDD = 3'h7;

  // Register-memory codes: broadcast group and conversion group
  localparam logic [2:0] MEM_16TO16 = 3'h0;
  localparam logic [2:0] MEM_1TO16  = 3'h1;
  localparam logic [2:0] MEM_4TO16  = 3'h2;
  localparam logic [2:0] MEM_UINT8  = 3'h4;
  localparam logic [2:0] MEM_SINT8  = 3'h5;
  localparam logic [2:0] MEM_UINT16 = 3'h6;
  localparam logic [2:0] MEM_SINT16 = 3'h7;

  // Identity and all-zero selector words, two bits per lane or element
  localparam logic [7:0] SEL_IDENT = 8'he4;
  localparam logic [7:0] SEL_ZERO  = 8'h00;

  // Extra latency of a register-register swizzle
  localparam int unsigned RR_EXTRA_LAT = 1;

  typedef enum logic [3:0] {
    VOSN_SRC_REG  = 4'h1,
    VOSN_SRC_MEM  = 4'h2,
    VOSN_SRC_SHUF = 4'h4,
    VOSN_SRC_IDLE = 4'h8
  } vosn_src_t;

endpackage : vosn_pkg

// >>> hw/vosn_lane_if.sv
// Interface carrying the first temporary copy between lane stage and element stage.
// Assumes both ends run on the core clock.
interface vosn_lane_if;
  import vosn_pkg::*;
  logic [VEC_W-1:0]      tmp1;
  logic                  valid;
  logic [ELEM_SEL_W-1:0] elem_sel;
  logic                  elem_bypass;
  logic [2:0]            conv;
  logic                  conv_en;
  logic                  illegal;
  logic                  rr;
  modport src (output tmp1, valid, elem_sel, elem_bypass, conv, conv_en, illegal, rr);
  modport dst (input  tmp1, valid, elem_sel, elem_bypass, conv, conv_en, illegal, rr);
endinterface : vosn_lane_if

// >>> hw/vosn_lane_mux.sv
// Lane selection stage: builds the first temporary copy from the second source.
// Assumes decoded lane selector and source form arrive with the issue strobe.
module vosn_lane_mux
  import vosn_pkg::*;
(
  input  wire logic                  clk_i,       // Core clock
  input  wire logic                  resetn_i,    // Async reset, active low
  input  wire logic                  ce_i,        // Clock enable
  input  wire logic                  issue_i,     // Operand valid this cycle
  input  wire logic [VEC_W-1:0]      src_i,       // Second source vector
  input  wire logic [LANE_SEL_W-1:0] lane_sel_i,  // Two bits per temp lane
  input  wire logic [ELEM_SEL_W-1:0] elem_sel_i,  // Element pattern
  input  wire logic                  elem_byp_i,  // Element stage pass-through
  input  wire logic [2:0]            conv_i,      // Conversion code
  input  wire logic                  conv_en_i,   // Conversion active
  input  wire logic                  illegal_i,   // Illegal encoding
  input  wire logic                  rr_i,        // Register-register swizzle
  vosn_lane_if.src                   lo           // To element stage
);

  logic [VEC_W-1:0]      tmp_d,  tmp_q;
  logic                  vld_d,  vld_q;
  logic [ELEM_SEL_W-1:0] es_d,   es_q;
  logic                  byp_d,  byp_q;
  logic [2:0]            cv_d,   cv_q;
  logic                  cve_d,  cve_q;
  logic                  ill_d,  ill_q;
  logic                  rr_d,   rr_q;

  always_comb
  begin
    tmp_d = tmp_q;
    vld_d = issue_i;
    es_d  = es_q;
    byp_d = byp_q;
    cv_d  = cv_q;
    cve_d = cve_q;
    ill_d = ill_q;
    rr_d  = rr_q;
    if (issue_i)
    begin
      // Any source lane to any temp lane, 128 bits wide
      for (int l = 0; l < NUM_LANES; l++)
      begin
        tmp_d[l*LANE_W +: LANE_W] = src_i[int'(lane_sel_i[2*l +: 2])*LANE_W +: LANE_W];
      end
      es_d  = elem_sel_i;
      byp_d = elem_byp_i;
      cv_d  = conv_i;
      cve_d = conv_en_i;
      ill_d = illegal_i;
      rr_d  = rr_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tmp_q <= '0;
      vld_q <= 1'b0;
      es_q  <= SEL_IDENT;
      byp_q <= 1'b1;
      cv_q  <= 3'h0;
      cve_q <= 1'b0;
      ill_q <= 1'b0;
      rr_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      tmp_q <= tmp_d;
      vld_q <= vld_d;
      es_q  <= es_d;
      byp_q <= byp_d;
      cv_q  <= cv_d;
      cve_q <= cve_d;
      ill_q <= ill_d;
      rr_q  <= rr_d;
    end
  end

  assign lo.tmp1        = tmp_q;
  assign lo.valid       = vld_q;
  assign lo.elem_sel    = es_q;
  assign lo.elem_bypass = byp_q;
  assign lo.conv        = cv_q;
  assign lo.conv_en     = cve_q;
  assign lo.illegal     = ill_q;
  assign lo.rr          = rr_q;

endmodule : vosn_lane_mux

// >>> dv/vosn_far_model.sv
// Far-side model: register file and load unit feeding the network, ALU taking its operand.
// Assumes the bench lets results arrive on the valid pulse only.
module vosn_far_model
  import vosn_pkg::*;
(
  input  wire logic             clk_i,      // Core clock
  input  wire logic [VEC_W-1:0] opnd_i,     // Operand from the network
  input  wire logic             valid_i,    // Operand valid pulse
  output logic      [VEC_W-1:0] reg_src_o,  // Register second source
  output logic      [VEC_W-1:0] mem_data_o, // Load data
  output logic      [VEC_W-1:0] got_o,      // Last operand taken
  output int                    seen_o      // Operands taken so far
);
  timeunit 1ns;
  timeprecision 1ps;
  // Source register is never written back: the swizzle works on a copy
  initial
  begin
    seen_o = 0;
    got_o = '0;
    for (int k = 0; k < 16; k++)
      reg_src_o[32*k +: 32] = {8'h5a, 8'(k), 16'h0f00 + 16'(k)};
    for (int j = 0; j < 64; j++)
      mem_data_o[8*j +: 8] = 8'(j * 37 + 19);
  end

  always @(posedge clk_i)
  begin
    if (valid_i)
    begin
      got_o <= opnd_i;
      seen_o <= seen_o + 1;
    end
  end
endmodule : vosn_far_model

// >>> dv/vosn_top_asserts.sv
// Checker for the operand swizzle network: result timing, flags and memory forms.
// Assumes ce_i stays high while it watches; bound to every vosn_top instance.
module vosn_top_asserts
  import vosn_pkg::*;
(
  input wire logic             clk_i,        // Clock
  input wire logic             resetn_i,     // Reset, active low
  input wire logic             ce_i,         // Clock enable
  input wire logic             issue_i,      // Issue strobe
  input wire logic             src_mem_i,    // Memory source
  input wire logic             shuf_i,       // Shuffle op
  input wire logic             is_float_i,   // Float op
  input wire logic             mod_given_i,  // Field present
  input wire logic             mem_conv_i,   // Conversion form
  input wire logic [SWZ_W-1:0] swz_i,        // Field
  input wire logic [VEC_W-1:0] reg_src_i,    // Register source
  input wire logic [VEC_W-1:0] mem_data_i,   // Load data
  input wire logic [VEC_W-1:0] opnd_o,       // Operand
  input wire logic             opnd_valid_o, // Operand valid
  input wire logic             illegal_o,    // Illegal flag
  input wire logic             rr_lat_o      // Swizzle flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rr_iss;
  logic       plain_iss;
  logic       bc_iss;
  logic       ill_code;
  logic [2:0] rr_hist_d;
  logic [2:0] rr_hist_q;

  // Plain ops near a register swizzle may be pushed back a cycle, so skip them
  assign rr_iss    = issue_i && ce_i && !src_mem_i && !shuf_i && mod_given_i;
  assign plain_iss = issue_i && ce_i && !rr_iss && (rr_hist_q == 3'h0);
  assign bc_iss    = plain_iss && src_mem_i && !shuf_i && mod_given_i && !mem_conv_i;
  assign ill_code  = !swz_i[2] || (is_float_i && (swz_i == MEM_SINT8 || swz_i == MEM_UINT16));
  assign rr_hist_d = {rr_hist_q[1:0], rr_iss};

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rr_hist_q <= 3'h0;
    else
      rr_hist_q <= rr_hist_d;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_rr_latency: assert property (rr_iss |-> ##3 (opnd_valid_o && rr_lat_o))
    else $error("register swizzle result not three cycles after issue");
  a_plain_latency: assert property (plain_iss |-> ##2 (opnd_valid_o && !rr_lat_o))
    else $error("plain result not two cycles after issue");
  a_flag_cause: assert property (rr_lat_o |-> opnd_valid_o && $past(rr_iss, 3))
    else $error("swizzle flag without a register swizzle three cycles back");
  a_ill_pair: assert property (illegal_o |-> opnd_valid_o && !rr_lat_o)
    else $error("illegal flag outside a memory result");
  a_ill_cause: assert property (plain_iss && src_mem_i && !shuf_i && mod_given_i && mem_conv_i
    |-> ##2 (illegal_o == $past(ill_code, 2)))
    else $error("illegal flag does not match the conversion code");
  a_one_bcast: assert property (bc_iss && swz_i == MEM_1TO16
    |-> ##2 (opnd_o == {NUM_ELEMS{$past(mem_data_i[ELEM_W-1:0], 2)}}))
    else $error("single element not replicated to all positions");
  a_four_bcast: assert property (bc_iss && swz_i == MEM_4TO16
    |-> ##2 (opnd_o == {NUM_LANES{$past(mem_data_i[LANE_W-1:0], 2)}}))
    else $error("loaded group not steered to every lane");
  a_full_load: assert property (plain_iss && src_mem_i && !shuf_i && !mod_given_i
    |-> ##2 (opnd_o == $past(mem_data_i, 2)))
    else $error("default memory operand altered");
  a_reg_ident: assert property (plain_iss && !src_mem_i && !shuf_i
    |-> ##2 (opnd_o == $past(reg_src_i, 2)))
    else $error("default register operand reordered");
  a_valid_cause: assert property (opnd_valid_o |-> $past(issue_i, 2) || $past(issue_i, 3))
    else $error("result without an issue two or three cycles back");

  c_rr: cover property (rr_iss);
  c_bcast: cover property (bc_iss);
  c_illegal: cover property (illegal_o);
endmodule : vosn_top_asserts

bind vosn_top vosn_top_asserts i_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .issue_i(issue_i),
  .src_mem_i(src_mem_i), .shuf_i(shuf_i), .is_float_i(is_float_i),
  .mod_given_i(mod_given_i), .mem_conv_i(mem_conv_i), .swz_i(swz_i),
  .reg_src_i(reg_src_i), .mem_data_i(mem_data_i), .opnd_o(opnd_o),
  .opnd_valid_o(opnd_valid_o), .illegal_o(illegal_o), .rr_lat_o(rr_lat_o)
);

// >>> dv/vosn_top_tb.sv
// Self-checking bench for the operand swizzle network with its far-side model.
// Assumes the checker is bound by its own file; ce_i is held high except for one issue cycle in the ce_freeze test.
module vosn_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vosn_pkg::*;

  logic             clk          = 1'b0;
  logic             resetn       = 1'b0;
  logic             issue        = 1'b0;
  logic             ce           = 1'b1;
  logic [4:0]       fl           = 5'h00;
  logic [2:0]       swz          = 3'h0;
  logic [7:0]       shuf_lane    = 8'h00;
  logic [7:0]       shuf_elem    = 8'h00;
  logic [VEC_W-1:0] reg_src;
  logic [VEC_W-1:0] mem_data;
  logic [VEC_W-1:0] opnd;
  logic [VEC_W-1:0] got;
  logic             opnd_valid;
  logic             illegal;
  logic             rr_lat;
  int               seen;
  int               errors       = 0;
  int               total_checks = 0;
  int               cycles       = 0;
  logic [7:0]       pat [8]      = '{8'he4, 8'hb1, 8'h4e, 8'hc9, 8'h00, 8'h55, 8'haa, 8'hff};

  always #10 clk = ~clk;

  // Flag order in fl: memory, shuffle, float, field given, conversion
  vosn_top i_dut (
    .clk_i(clk), .resetn_i(resetn), .ce_i(ce), .issue_i(issue),
    .src_mem_i(fl[4]), .shuf_i(fl[3]), .is_float_i(fl[2]), .mod_given_i(fl[1]),
    .mem_conv_i(fl[0]), .swz_i(swz), .shuf_lane_i(shuf_lane), .shuf_elem_i(shuf_elem),
    .reg_src_i(reg_src), .mem_data_i(mem_data), .opnd_o(opnd), .opnd_valid_o(opnd_valid),
    .illegal_o(illegal), .rr_lat_o(rr_lat)
  );

  vosn_far_model i_far (
    .clk_i(clk), .opnd_i(opnd), .valid_i(opnd_valid), .reg_src_o(reg_src),
    .mem_data_o(mem_data), .got_o(got), .seen_o(seen)
  );

  function automatic logic [VEC_W-1:0] perm(logic [VEC_W-1:0] v, logic [7:0] ls,
                                            logic [7:0] es);
    logic [VEC_W-1:0] r;
    for (int l = 0; l < 4; l++)
      for (int e = 0; e < 4; e++)
        r[128*l+32*e +: 32] = v[128*ls[2*l +: 2] + 32*es[2*e +: 2] +: 32];
    return r;
  endfunction : perm

  function automatic logic [VEC_W-1:0] cvt(logic [VEC_W-1:0] v, logic [2:0] c);
    logic [VEC_W-1:0] r;
    for (int i = 0; i < 16; i++)
      case (c)
        MEM_UINT8:  r[32*i +: 32] = {24'h0, v[8*i +: 8]};
        MEM_SINT8:  r[32*i +: 32] = {{24{v[8*i+7]}}, v[8*i +: 8]};
        MEM_UINT16: r[32*i +: 32] = {16'h0, v[16*i +: 16]};
        default:    r[32*i +: 32] = {{16{v[16*i+15]}}, v[16*i +: 16]};
      endcase
    return r;
  endfunction : cvt

  task automatic chk_vec(string what, logic [VEC_W-1:0] exp, logic [VEC_W-1:0] seen_v);
    total_checks++;
    if (seen_v !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : chk_vec

  task automatic chk_bit(string what, logic exp, logic seen_b);
    total_checks++;
    if (seen_b !== exp)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, seen_b);
    end
  endtask : chk_bit

  task automatic chk_num(string what, int exp, int seen_n);
    total_checks++;
    if (seen_n != exp)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen_n);
    end
  endtask : chk_num

  // Issues one op, waits for its result and judges it; res is {illegal, swizzle, data check}
  task automatic run_op(logic [4:0] f, logic [2:0] z, logic [7:0] ls, logic [7:0] es,
                        logic [VEC_W-1:0] exp, int lat, logic [2:0] res);
    int n;
    @(negedge clk);
    fl = f;
    swz = z;
    shuf_lane = ls;
    shuf_elem = es;
    issue = 1'b1;
    @(negedge clk);
    issue = 1'b0;
    n = 1;
    while (opnd_valid !== 1'b1 && n < 6)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_num("latency", lat, n);
    if (res[0])
      chk_vec("operand", exp, opnd);
    chk_bit("illegal flag", res[2], illegal);
    chk_bit("swizzle flag", res[1], rr_lat);
  endtask : run_op

  task automatic t_reg_patterns();
    for (int k = 0; k < 8; k++)
      run_op(5'h02, 3'(k), 8'h00, 8'h00, perm(reg_src, SEL_IDENT, pat[k]), 3, 3'h3);
    run_op(5'h00, SWZ_BBBB, 8'h00, 8'h00, reg_src, 2, 3'h1);
    $display("test reg_patterns done");
  endtask : t_reg_patterns

  task automatic t_mem_bcast();
    run_op(5'h12, MEM_16TO16, 8'h00, 8'h00, mem_data, 2, 3'h1);
    run_op(5'h12, MEM_1TO16, 8'h00, 8'h00, {16{mem_data[31:0]}}, 2, 3'h1);
    run_op(5'h12, MEM_4TO16, 8'h00, 8'h00, {4{mem_data[127:0]}}, 2, 3'h1);
    run_op(5'h10, MEM_4TO16, 8'h00, 8'h00, mem_data, 2, 3'h1);
    $display("test mem_bcast done");
  endtask : t_mem_bcast

  task automatic t_mem_conv();
    for (int k = 4; k < 8; k++)
      run_op(5'h13, 3'(k), 8'h00, 8'h00, cvt(mem_data, 3'(k)), 2, 3'h1);
    run_op(5'h17, MEM_UINT8, 8'h00, 8'h00, cvt(mem_data, MEM_UINT8), 2, 3'h1);
    run_op(5'h17, MEM_SINT16, 8'h00, 8'h00, cvt(mem_data, MEM_SINT16), 2, 3'h1);
    run_op(5'h17, MEM_SINT8, 8'h00, 8'h00, mem_data, 2, 3'h5);
    run_op(5'h17, MEM_UINT16, 8'h00, 8'h00, mem_data, 2, 3'h5);
    run_op(5'h13, 3'h3, 8'h00, 8'h00, mem_data, 2, 3'h5);
    $display("test mem_conv done");
  endtask : t_mem_conv

  task automatic t_shuffle();
    run_op(5'h1a, SWZ_DACB, 8'h1b, 8'h27, perm(reg_src, 8'h1b, 8'h27), 2, 3'h1);
    $display("test shuffle done");
  endtask : t_shuffle

  task automatic t_back_to_back();
    @(negedge clk);
    fl = 5'h10;
    issue = 1'b1;
    @(negedge clk);
    fl = 5'h00;
    @(negedge clk);
    issue = 1'b0;
    chk_bit("first valid", 1'b1, opnd_valid);
    chk_vec("first operand", mem_data, opnd);
    @(posedge clk);
    #1;
    chk_bit("second valid", 1'b1, opnd_valid);
    chk_vec("second operand", reg_src, opnd);
    $display("test back_to_back done");
  endtask : t_back_to_back

  // Issue with the clock enable low: nothing may be taken or change
  task automatic t_ce_freeze();
    int s0;
    repeat (2) @(negedge clk);
    s0 = seen;
    ce = 1'b0;
    fl = 5'h10;
    issue = 1'b1;
    @(negedge clk);
    ce = 1'b1;
    issue = 1'b0;
    repeat (4) @(negedge clk);
    chk_num("frozen count", s0, seen);
    chk_vec("frozen operand", reg_src, opnd);
    chk_vec("model operand", reg_src, got);
    $display("test ce_freeze done");
  endtask : t_ce_freeze

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_reg_patterns();
    t_mem_bcast();
    t_mem_conv();
    t_shuffle();
    t_back_to_back();
    t_ce_freeze();
    @(negedge clk);
    chk_num("operand count", 25, seen);
    close_out();
  end
endmodule : vosn_top_tb
